// ---- shared/pvlm_pkg.sv ----
// Constants and carrier types for the power-valid limit monitor
package pvlm_pkg;

  // ----------------------------------------------------------------
  // Register pointers
  // ----------------------------------------------------------------
  localparam logic [7:0] PVLM_PTR_UPPER = 8'h10;
  localparam logic [7:0] PVLM_PTR_LOWER = 8'h11;
  localparam logic [7:0] PVLM_PTR_MAKER = 8'hFE;
  localparam logic [7:0] PVLM_PTR_DIE = 8'hFF;

  // ----------------------------------------------------------------
  // Reset and identity values
  // ----------------------------------------------------------------
  localparam logic [15:0] PVLM_UPPER_RST = 16'h2710;
  localparam logic [15:0] PVLM_LOWER_RST = 16'h2328;
  // Arbitrary identity values
  localparam logic [15:0] PVLM_MAKER_ID = 16'hA5C3;
  localparam logic [15:0] PVLM_DIE_IDENTITY = 16'h0B17;
  localparam logic [15:0] PVLM_UNMAPPED = 16'h0000;

  // ----------------------------------------------------------------
  // Field layout of limit words and readings
  // ----------------------------------------------------------------
  localparam int PVLM_SIGN_BIT = 15;
  localparam int PVLM_FIELD_MSB = 14;
  localparam int PVLM_FIELD_LSB = 3;
  localparam logic [15:0] PVLM_CMP_MASK = 16'hFFF8;
  localparam int PVLM_MODE_BUS_BIT = 1;
  localparam int PVLM_CHANNELS = 3;

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  localparam logic [6:0] PVLM_SLAVE_ADDR = 7'h40;
  localparam logic [3:0] PVLM_BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] PVLM_IDX_PTR = 2'h0;
  localparam logic [1:0] PVLM_IDX_MSB = 2'h1;
  localparam logic [1:0] PVLM_IDX_LSB = 2'h2;

  typedef enum logic [2:0] {
    PVLM_ST_IDLE,
    PVLM_ST_ADDR,
    PVLM_ST_ACK,
    PVLM_ST_RX,
    PVLM_ST_TX,
    PVLM_ST_MACK
  } pvlm_state_t;

  // New set of bus-voltage results from the conversion engine
  typedef struct packed {
    logic stored;
    logic [PVLM_CHANNELS-1:0] enabled;
    logic [PVLM_CHANNELS-1:0][15:0] reading;
  } pvlm_bus_t;

  // Shunt critical-limit status from the conversion engine
  typedef struct packed {
    logic over;
    logic conv_done;
  } pvlm_crit_t;

endpackage

// ---- src/pvlm_chan_cmp.sv ----
// One channel's comparison against the upper and lower power-valid limits
`timescale 1ns/100ps
module pvlm_chan_cmp (
  input wire logic [15:0] reading,
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  output logic above_upper,
  output logic below_lower
);

  logic signed [15:0] rd_s;
  logic signed [15:0] up_s;
  logic signed [15:0] lo_s;

  // Reserved low bits take no part; bit 15 is a two's-complement sign
  assign rd_s = $signed(reading & pvlm_pkg::PVLM_CMP_MASK);
  assign up_s = $signed(upper & pvlm_pkg::PVLM_CMP_MASK);
  assign lo_s = $signed(lower & pvlm_pkg::PVLM_CMP_MASK);
  assign above_upper = rd_s > up_s;
  assign below_lower = rd_s < lo_s;

endmodule

// ---- src/pvlm_top.sv ----
// Power-valid limit monitor with two-wire register slave and critical alert timing
`timescale 1ns/100ps
module pvlm_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [2:0] meas_select_bits,
  input wire pvlm_pkg::pvlm_bus_t bus_results,
  input wire pvlm_pkg::pvlm_crit_t crit_status,
  output logic power_valid_out,
  output logic valid_status_flag,
  output logic critical_alert_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic scl_prev_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall = ~scl_sync_reg & scl_prev_reg;
  assign bus_start = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign bus_stop = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

  // ----------------------------------------------------------------
  // Serial slave and limit registers
  // ----------------------------------------------------------------
  pvlm_pkg::pvlm_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] msb_reg, msb_next;
  logic [1:0] idx_reg, idx_next;
  logic rw_reg, rw_next;
  logic drive_low_reg, drive_low_next;
  logic [15:0] tx_word_reg, tx_word_next;
  logic tx_sel_reg, tx_sel_next;
  logic [15:0] upper_reg, upper_next;
  logic [15:0] lower_reg, lower_next;

  function automatic logic [15:0] read_mux(input logic [7:0] ptr, input logic [15:0] up,
                                           input logic [15:0] lo);
    case (ptr)
      pvlm_pkg::PVLM_PTR_UPPER: read_mux = up;
      pvlm_pkg::PVLM_PTR_LOWER: read_mux = lo;
      pvlm_pkg::PVLM_PTR_MAKER: read_mux = pvlm_pkg::PVLM_MAKER_ID;
      pvlm_pkg::PVLM_PTR_DIE: read_mux = pvlm_pkg::PVLM_DIE_IDENTITY;
      default: read_mux = pvlm_pkg::PVLM_UNMAPPED;
    endcase
  endfunction

  always_comb begin
    logic [7:0] tx_byte;
    tx_byte = tx_sel_reg ? tx_word_reg[7:0] : tx_word_reg[15:8];
    st_next = st_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    msb_next = msb_reg;
    idx_next = idx_reg;
    rw_next = rw_reg;
    drive_low_next = drive_low_reg;
    tx_word_next = tx_word_reg;
    tx_sel_next = tx_sel_reg;
    upper_next = upper_reg;
    lower_next = lower_reg;
    if (bus_start) begin
      // Repeated start restarts addressing but keeps the pointer
      st_next = pvlm_pkg::PVLM_ST_ADDR;
      cnt_next = 4'h0;
      idx_next = pvlm_pkg::PVLM_IDX_PTR;
      drive_low_next = 1'b0;
    end else if (bus_stop) begin
      st_next = pvlm_pkg::PVLM_ST_IDLE;
      drive_low_next = 1'b0;
    end else begin
      case (st_reg)
        pvlm_pkg::PVLM_ST_IDLE: begin
        end
        pvlm_pkg::PVLM_ST_ADDR: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_sync_reg};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == pvlm_pkg::PVLM_BITS_PER_BYTE) begin
            if (shift_reg[7:1] == pvlm_pkg::PVLM_SLAVE_ADDR) begin
              rw_next = shift_reg[0];
              drive_low_next = 1'b1;
              st_next = pvlm_pkg::PVLM_ST_ACK;
              // Word is frozen here so both bytes come from one value
              tx_word_next = read_mux(ptr_reg, upper_reg, lower_reg);
              tx_sel_next = 1'b0;
            end else begin
              st_next = pvlm_pkg::PVLM_ST_IDLE;
            end
          end
        end
        pvlm_pkg::PVLM_ST_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              drive_low_next = ~tx_byte[7];
              shift_next = {tx_byte[6:0], 1'b0};
              cnt_next = 4'h1;
              st_next = pvlm_pkg::PVLM_ST_TX;
            end else begin
              drive_low_next = 1'b0;
              cnt_next = 4'h0;
              st_next = pvlm_pkg::PVLM_ST_RX;
            end
          end
        end
        pvlm_pkg::PVLM_ST_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_sync_reg};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == pvlm_pkg::PVLM_BITS_PER_BYTE) begin
            drive_low_next = 1'b1;
            st_next = pvlm_pkg::PVLM_ST_ACK;
            case (idx_reg)
              pvlm_pkg::PVLM_IDX_PTR: begin
                ptr_next = shift_reg;
                idx_next = pvlm_pkg::PVLM_IDX_MSB;
              end
              pvlm_pkg::PVLM_IDX_MSB: begin
                msb_next = shift_reg;
                idx_next = pvlm_pkg::PVLM_IDX_LSB;
              end
              default: begin
                // Identity registers ignore writes
                if (ptr_reg == pvlm_pkg::PVLM_PTR_UPPER) begin
                  upper_next = {msb_reg, shift_reg};
                end
                if (ptr_reg == pvlm_pkg::PVLM_PTR_LOWER) begin
                  lower_next = {msb_reg, shift_reg};
                end
                idx_next = pvlm_pkg::PVLM_IDX_MSB;
              end
            endcase
          end
        end
        pvlm_pkg::PVLM_ST_TX: begin
          if (scl_fall) begin
            if (cnt_reg < pvlm_pkg::PVLM_BITS_PER_BYTE) begin
              drive_low_next = ~shift_reg[7];
              shift_next = {shift_reg[6:0], 1'b0};
              cnt_next = cnt_reg + 4'h1;
            end else begin
              drive_low_next = 1'b0;
              tx_sel_next = ~tx_sel_reg;
              st_next = pvlm_pkg::PVLM_ST_MACK;
            end
          end
        end
        pvlm_pkg::PVLM_ST_MACK: begin
          if (scl_rise) begin
            st_next = sda_sync_reg ? pvlm_pkg::PVLM_ST_IDLE : pvlm_pkg::PVLM_ST_ACK;
          end
        end
        default: begin
          st_next = pvlm_pkg::PVLM_ST_IDLE;
          drive_low_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= pvlm_pkg::PVLM_ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      msb_reg <= 8'h00;
      idx_reg <= pvlm_pkg::PVLM_IDX_PTR;
      rw_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      tx_word_reg <= 16'h0000;
      tx_sel_reg <= 1'b0;
      upper_reg <= pvlm_pkg::PVLM_UPPER_RST;
      lower_reg <= pvlm_pkg::PVLM_LOWER_RST;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      msb_reg <= msb_next;
      idx_reg <= idx_next;
      rw_reg <= rw_next;
      drive_low_reg <= drive_low_next;
      tx_word_reg <= tx_word_next;
      tx_sel_reg <= tx_sel_next;
      upper_reg <= upper_next;
      lower_reg <= lower_next;
    end
  end

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_low_reg;

  // ----------------------------------------------------------------
  // Channel comparisons
  // ----------------------------------------------------------------
  logic [pvlm_pkg::PVLM_CHANNELS-1:0] above;
  logic [pvlm_pkg::PVLM_CHANNELS-1:0] below;

  for (genvar i = 0; i < pvlm_pkg::PVLM_CHANNELS; i++) begin : g_chan
    pvlm_chan_cmp u_cmp (
      .reading(bus_results.reading[i]),
      .upper(upper_reg),
      .lower(lower_reg),
      .above_upper(above[i]),
      .below_lower(below[i])
    );
  end

  // ----------------------------------------------------------------
  // Power-valid and critical alert state
  // ----------------------------------------------------------------
  logic pv_reg, pv_next;
  logic crit_pend_reg, crit_pend_next;
  logic crit_n_reg, crit_n_next;
  logic evaluate;
  logic all_above;
  logic any_below;

  // Without bus measurement nothing new arrives, so the state holds
  assign evaluate = bus_results.stored & meas_select_bits[pvlm_pkg::PVLM_MODE_BUS_BIT]
                    & (|bus_results.enabled);
  assign all_above = &(above | ~bus_results.enabled);
  assign any_below = |(below & bus_results.enabled);

  always_comb begin
    pv_next = pv_reg;
    crit_pend_next = crit_pend_reg;
    crit_n_next = crit_n_reg;
    if (evaluate) begin
      if (!pv_reg && all_above) begin
        pv_next = 1'b1;
      end else if (pv_reg && any_below) begin
        pv_next = 1'b0;
      end
    end
    // Over-limit seen mid-conversion is held until the cycle ends
    if (crit_status.conv_done) begin
      crit_n_next = ~(crit_pend_reg | crit_status.over);
      crit_pend_next = 1'b0;
    end else if (crit_status.over) begin
      crit_pend_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pv_reg <= 1'b0;
      crit_pend_reg <= 1'b0;
      crit_n_reg <= 1'b1;
    end else begin
      pv_reg <= pv_next;
      crit_pend_reg <= crit_pend_next;
      crit_n_reg <= crit_n_next;
    end
  end

  assign power_valid_out = pv_reg;
  assign valid_status_flag = pv_reg;
  assign critical_alert_n = crit_n_reg;

endmodule

// ---- test/pvlm_top_asserts.sv ----
// Port assertions for the power-valid limit monitor
`timescale 1ns/100ps
module pvlm_top_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [2:0] meas_select_bits,
  input wire pvlm_pkg::pvlm_bus_t bus_results,
  input wire pvlm_pkg::pvlm_crit_t crit_status,
  input wire logic power_valid_out,
  input wire logic valid_status_flag,
  input wire logic critical_alert_n
);
  logic qual;
  assign qual = bus_results.stored & meas_select_bits[1] & (|bus_results.enabled);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_rise_cause: assert property ($rose(power_valid_out) |-> $past(qual))
    else $error("valid rose with no result set");
  a_fall_cause: assert property ($fell(power_valid_out) |-> $past(qual))
    else $error("valid fell with no result set");
  a_hold_idle: assert property (
    !$past(qual) |-> $stable(power_valid_out))
    else $error("valid moved between result sets");
  a_mode_gate: assert property (
    !$past(meas_select_bits[1]) |-> $stable(power_valid_out))
    else $error("valid moved with bus mode off");
  a_no_enabled: assert property (
    $past(bus_results.enabled) == 3'h0 |-> $stable(power_valid_out))
    else $error("valid moved with no channel enabled");
  a_flag_mirror: assert property (valid_status_flag == power_valid_out)
    else $error("flag differs from valid output");
  a_alert_wait: assert property (
    !$past(crit_status.conv_done) |-> $stable(critical_alert_n))
    else $error("alert moved outside conversion end");
  a_alert_set: assert property (
    $past(crit_status.conv_done) && $past(crit_status.over) |-> !critical_alert_n)
    else $error("alert missing after conversion end");
  c_pv_rise: cover property ($rose(power_valid_out));
  c_pv_fall: cover property ($fell(power_valid_out));
  c_alert_low: cover property ($fell(critical_alert_n));
endmodule
bind pvlm_top pvlm_top_asserts pvlm_top_asserts_i (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .meas_select_bits(meas_select_bits),
  .bus_results(bus_results), .crit_status(crit_status),
  .power_valid_out(power_valid_out), .valid_status_flag(valid_status_flag),
  .critical_alert_n(critical_alert_n)
);

// ---- test/pvlm_host.sv ----
// Two-wire host model framing register writes and reads
`timescale 1ns/100ps
module pvlm_host (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_rel
);
  logic ack_all;
  initial begin
    scl = 1'h1;
    sda_rel = 1'h1;
    ack_all = 1'h1;
  end
  // Eight clocks per phase keeps both above the slave's three
  task automatic bit_io(input logic d, output logic s);
    sda_rel = d;
    repeat (8) @(negedge clk);
    scl = 1'h1;
    repeat (4) @(negedge clk);
    s = sda_in;
    repeat (4) @(negedge clk);
    scl = 1'h0;
  endtask
  task automatic start;
    sda_rel = 1'h1;
    repeat (8) @(negedge clk);
    scl = 1'h1;
    repeat (8) @(negedge clk);
    sda_rel = 1'h0;
    repeat (8) @(negedge clk);
    scl = 1'h0;
  endtask
  task automatic stop;
    sda_rel = 1'h0;
    repeat (8) @(negedge clk);
    scl = 1'h1;
    repeat (8) @(negedge clk);
    sda_rel = 1'h1;
    repeat (8) @(negedge clk);
  endtask
  task automatic wb(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'h1, s);
    if (s !== 1'h0) begin
      ack_all = 1'h0;
    end
  endtask
  task automatic rb(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, s);
      b[i] = s;
    end
    bit_io(nack, s);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [15:0] d, output logic ok);
    ack_all = 1'h1;
    start();
    wb({a, 1'h0});
    wb(p);
    wb(d[15:8]);
    wb(d[7:0]);
    stop();
    ok = ack_all;
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] d, output logic ok);
    ack_all = 1'h1;
    start();
    wb({pvlm_pkg::PVLM_SLAVE_ADDR, 1'h0});
    wb(p);
    start();
    wb({pvlm_pkg::PVLM_SLAVE_ADDR, 1'h1});
    rb(1'h0, d[15:8]);
    rb(1'h1, d[7:0]);
    stop();
    ok = ack_all;
  endtask
endmodule

// ---- test/pvlm_tb_top.sv ----
// Self-checking bench for the power-valid limit monitor
`timescale 1ns/100ps
module pvlm_tb_top;
  typedef struct packed {
    logic [2:0] md;
    logic [2:0] en;
    logic [15:0] r0;
    logic [15:0] r1;
    logic [15:0] r2;
    logic pv;
  } pvlm_row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic scl;
  logic sda_rel;
  logic sda_w;
  logic sda_out;
  logic sda_oe_n;
  logic [2:0] meas = 3'h0;
  pvlm_pkg::pvlm_bus_t bres = '0;
  pvlm_pkg::pvlm_crit_t crit = '0;
  logic pv;
  logic flag;
  logic alert_n;
  logic [15:0] rd_val;
  logic ok;
  int n_errors = 0;
  int checked = 0;
  pvlm_row_t rows [11] = '{
    '{3'h1, 3'h7, 16'h2718, 16'h2718, 16'h2718, 1'h0},
    '{3'h7, 3'h7, 16'h2718, 16'h2718, 16'h2710, 1'h0},
    '{3'h7, 3'h7, 16'h2717, 16'h2717, 16'h2717, 1'h0},
    '{3'h7, 3'h3, 16'h2718, 16'h2718, 16'h0000, 1'h1},
    '{3'h7, 3'h7, 16'h2400, 16'h2400, 16'h2400, 1'h1},
    '{3'h7, 3'h7, 16'h2328, 16'h2400, 16'h2400, 1'h1},
    '{3'h7, 3'h7, 16'h2400, 16'h2327, 16'h2400, 1'h0},
    '{3'h7, 3'h7, 16'h2718, 16'h2718, 16'h8000, 1'h0},
    '{3'h7, 3'h7, 16'h2718, 16'h2718, 16'h2718, 1'h1},
    '{3'h7, 3'h0, 16'h0000, 16'h0000, 16'h0000, 1'h1},
    '{3'h1, 3'h7, 16'h0000, 16'h0000, 16'h0000, 1'h1}
  };
  // Over, conversion end, expected alert level
  logic [2:0] cs [5] = '{3'h5, 3'h1, 3'h2, 3'h6, 3'h3};
  always #5 clk = ~clk;
  assign sda_w = sda_rel & (sda_oe_n | sda_out);
  pvlm_top pvlm_top_i (
    .clk(clk),
    .rst(rst),
    .scl_in(scl),
    .sda_in(sda_w),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .meas_select_bits(meas),
    .bus_results(bres),
    .crit_status(crit),
    .power_valid_out(pv),
    .valid_status_flag(flag),
    .critical_alert_n(alert_n)
  );
  pvlm_host pvlm_host_i (
    .clk(clk),
    .sda_in(sda_w),
    .scl(scl),
    .sda_rel(sda_rel)
  );
  // ----
  // Checks
  // ----
  task automatic chk1(input string nm, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic pulse(input pvlm_row_t r);
    meas = r.md;
    bres = {1'h1, r.en, r.r2, r.r1, r.r0};
    @(negedge clk);
    bres.stored = 1'h0;
    // Strobe stays low one edge, never lowered and raised at once
    @(negedge clk);
    chk1("power_valid_out", r.pv, pv);
    chk1("valid_status_flag", r.pv, flag);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] p, input logic [15:0] e);
    pvlm_host_i.rd(p, rd_val, ok);
    chk1("read_ack", 1'h1, ok);
    chk16(nm, e, rd_val);
  endtask
  task automatic wr_chk(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                        input logic e);
    pvlm_host_i.wr(a, p, d, ok);
    chk1("write_ack", e, ok);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      pulse(rows[i]);
    end
    rst = 1'h1;
    repeat (4) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    chk1("pv_after_reset", 1'h0, pv);
    chk1("alert_after_reset", 1'h1, alert_n);
    repeat (3) @(negedge clk);
    rd_chk("upper_reset", pvlm_pkg::PVLM_PTR_UPPER, 16'h2710);
    rd_chk("lower_reset", pvlm_pkg::PVLM_PTR_LOWER, 16'h2328);
    rd_chk("maker", pvlm_pkg::PVLM_PTR_MAKER, pvlm_pkg::PVLM_MAKER_ID);
    rd_chk("die", pvlm_pkg::PVLM_PTR_DIE, pvlm_pkg::PVLM_DIE_IDENTITY);
    rd_chk("unmapped", 8'h00, 16'h0000);
    wr_chk(7'h41, pvlm_pkg::PVLM_PTR_UPPER, 16'h0000, 1'h0);
    wr_chk(pvlm_pkg::PVLM_SLAVE_ADDR, pvlm_pkg::PVLM_PTR_MAKER, 16'h0000, 1'h1);
    wr_chk(pvlm_pkg::PVLM_SLAVE_ADDR, pvlm_pkg::PVLM_PTR_DIE, 16'h0000, 1'h1);
    rd_chk("upper_kept", pvlm_pkg::PVLM_PTR_UPPER, 16'h2710);
    rd_chk("maker_ro", pvlm_pkg::PVLM_PTR_MAKER, pvlm_pkg::PVLM_MAKER_ID);
    rd_chk("die_ro", pvlm_pkg::PVLM_PTR_DIE, pvlm_pkg::PVLM_DIE_IDENTITY);
    wr_chk(pvlm_pkg::PVLM_SLAVE_ADDR, pvlm_pkg::PVLM_PTR_UPPER, 16'hFFFF, 1'h1);
    wr_chk(pvlm_pkg::PVLM_SLAVE_ADDR, pvlm_pkg::PVLM_PTR_LOWER, 16'hFFF0, 1'h1);
    rd_chk("upper_neg", pvlm_pkg::PVLM_PTR_UPPER, 16'hFFFF);
    rd_chk("lower_neg", pvlm_pkg::PVLM_PTR_LOWER, 16'hFFF0);
    pulse('{3'h7, 3'h7, 16'h0000, 16'h0000, 16'h0000, 1'h1});
    pulse('{3'h7, 3'h7, 16'hFFE8, 16'h0000, 16'h0000, 1'h0});
    foreach (cs[i]) begin
      crit = {cs[i][2], cs[i][1]};
      @(negedge clk);
      crit = '0;
      @(negedge clk);
      chk1("critical_alert_n", cs[i][0], alert_n);
    end
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule
